/* design/plc_link_cap.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module plc_link_cap (
    input wire logic core_clk, // 25 MHz device clock
    input wire logic resetn, // async fundamental reset
    input wire plc_pkg::plc_axi_req_t axi_req, // axi4-lite master side
    output plc_pkg::plc_axi_rsp_t axi_rsp, // axi4-lite slave side
    input wire plc_pkg::plc_strap_t strap_pins, // lane width, port index, 1.1 mode
    output logic [5:0] train_width, // width the link trains at
    output logic init_done // straps captured, fields valid
);
    // only the four listed lane codes train as written
    function automatic logic width_ok(input logic [5:0] w);
        return (w == plc_pkg::WIDTH_X1) || (w == plc_pkg::WIDTH_X2) ||
               (w == plc_pkg::WIDTH_X4) || (w == plc_pkg::WIDTH_X12);
    endfunction

    // byte lanes not strobed keep their current value
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (cur & ~m) | (wd & m);
    endfunction

    plc_pkg::plc_strap_t sync1_r;
    plc_pkg::plc_strap_t sync2_r;
    logic [1:0] init_cnt_r;
    logic init_done_r;
    logic [5:0] width_r;
    logic [2:0] l0s_val_r;
    logic l0s_ovr_r;
    logic [2:0] l1_r;
    logic cpm_r;
    logic sde_r;
    logic dlla_r;
    logic lbn_r;
    logic [7:0] port_id_r;
    logic common_refclk_config_r;
    logic unlock_r;
    logic [5:0] train_width_r;
    logic aw_full_r;
    logic w_full_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    // strap pins come from outside; two flops before any use
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= strap_pins;
            sync2_r <= sync1_r;
        end
    end

    // load happens once the synchroniser holds settled strap values
    wire init_load = !init_done_r && (init_cnt_r == plc_pkg::INIT_CYCLES - 2'h1);
    // port index 0 is the upstream port
    wire is_upstream = (sync2_r.port_index == plc_pkg::UPSTREAM_PORT);

    // counter stops once loaded, so straps are sampled exactly once per reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            init_cnt_r <= '0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            init_cnt_r <= init_cnt_r + 2'h1;
            init_done_r <= init_load;
        end
    end

    // axi write channel
    wire aw_hs = axi_req.awvalid && axi_rsp.awready;
    wire w_hs = axi_req.wvalid && axi_rsp.wready;
    // a held address or data beat waits here until its partner arrives
    wire aw_have = aw_full_r || aw_hs;
    wire w_have = w_full_r || w_hs;
    wire do_wr = aw_have && w_have && !bvalid_r;
    wire [11:0] wr_addr = aw_full_r ? awaddr_r : axi_req.awaddr;
    wire [31:0] wr_data = w_full_r ? wdata_r : axi_req.wdata;
    wire [3:0] wr_strb = w_full_r ? wstrb_r : axi_req.wstrb;
    // one decoder per register; anything else answers with an error
    wire wr_cap = do_wr && (wr_addr == plc_pkg::ADDR_LINK_CAP);
    wire wr_ctl = do_wr && (wr_addr == plc_pkg::ADDR_LINK_CTL);
    wire wr_sw = do_wr && (wr_addr == plc_pkg::ADDR_SW_CTL);
    wire wr_mapped = wr_cap || wr_ctl || wr_sw;
    // locked fields only move after init and while unlocked
    wire cap_load = wr_cap && unlock_r && init_done_r;

    // register views
    // latency follows the clock bit live; an unlocked byte-1 write pins it instead
    wire [2:0] l0s_field = l0s_ovr_r ? l0s_val_r : (common_refclk_config_r ? plc_pkg::L0S_COMMON : plc_pkg::L0S_SEPARATE);
    wire [31:0] link_cap = {port_id_r, 2'h0, lbn_r, dlla_r, sde_r, cpm_r, l1_r, l0s_field,
                            plc_pkg::POWER_STATE_SUPPORT_VAL, width_r, plc_pkg::SPEED_RST};
    wire [31:0] link_ctl = 32'(common_refclk_config_r) << plc_pkg::COMMON_REFCLK_CONFIG_BIT;
    wire [31:0] sw_ctl = 32'(unlock_r) << plc_pkg::UNLOCK_BIT;
    wire [31:0] cap_new = merge(link_cap, wr_data, wr_strb);
    wire [31:0] ctl_new = merge(link_ctl, wr_data, wr_strb);
    wire [31:0] sw_new = merge(sw_ctl, wr_data, wr_strb);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= plc_pkg::RESP_OKAY;
        end else begin
            if (aw_hs && !do_wr) begin
                aw_full_r <= 1'b1;
                awaddr_r <= axi_req.awaddr;
            end else if (do_wr) begin
                aw_full_r <= 1'b0;
            end
            if (w_hs && !do_wr) begin
                w_full_r <= 1'b1;
                wdata_r <= axi_req.wdata;
                wstrb_r <= axi_req.wstrb;
            end else if (do_wr) begin
                w_full_r <= 1'b0;
            end
            // the response drops only when the master takes it
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
            end else if (axi_req.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // capability fields
    // lane straps are only trusted after the synchroniser has settled
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            width_r <= plc_pkg::WIDTH_X1;
            l0s_val_r <= plc_pkg::L0S_SEPARATE;
            l0s_ovr_r <= 1'b0;
            l1_r <= plc_pkg::L1_RST;
            cpm_r <= plc_pkg::CPM_RST;
            sde_r <= 1'b0;
            dlla_r <= 1'b0;
            lbn_r <= 1'b0;
            port_id_r <= '0;
        end else if (init_load) begin
            width_r <= sync2_r.lane_width;
            sde_r <= !is_upstream;
            dlla_r <= !is_upstream;
            lbn_r <= !is_upstream && !sync2_r.compat_1p1;
            port_id_r <= {5'h00, sync2_r.port_index};
        end else if (cap_load) begin
            width_r <= cap_new[plc_pkg::WID_LSB +: 6];
            l0s_val_r <= cap_new[plc_pkg::L0S_LSB +: 3];
            l0s_ovr_r <= wr_strb[1];
            l1_r <= cap_new[plc_pkg::L1_LSB +: 3];
            cpm_r <= cap_new[plc_pkg::CPM_BIT];
            sde_r <= cap_new[plc_pkg::SDE_BIT];
            dlla_r <= cap_new[plc_pkg::DLLA_BIT];
            lbn_r <= cap_new[plc_pkg::LBN_BIT];
        end
    end

    // control bits and trained width
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            common_refclk_config_r <= 1'b0;
            unlock_r <= 1'b0;
            train_width_r <= plc_pkg::WIDTH_X1;
        end else begin
            if (wr_ctl) common_refclk_config_r <= ctl_new[plc_pkg::COMMON_REFCLK_CONFIG_BIT];
            if (wr_sw) unlock_r <= sw_new[plc_pkg::UNLOCK_BIT];
            // registered so the link side never sees a half-written code
            // invalid falls back to x1
            train_width_r <= width_ok(width_r) ? width_r : plc_pkg::WIDTH_X1;
        end
    end

    // axi read channel; the word is captured at the address handshake
    wire ar_hs = axi_req.arvalid && axi_rsp.arready;
    wire rd_cap = axi_req.araddr == plc_pkg::ADDR_LINK_CAP;
    wire rd_ctl = axi_req.araddr == plc_pkg::ADDR_LINK_CTL;
    wire rd_sw = axi_req.araddr == plc_pkg::ADDR_SW_CTL;
    // unmapped reads return zero so nothing stale leaks out
    wire [31:0] rd_word = rd_cap ? link_cap :
                          rd_ctl ? link_ctl :
                          rd_sw ? sw_ctl :
                          32'h0000_0000;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= plc_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rd_cap || rd_ctl || rd_sw) ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
        end else if (axi_req.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // readies drop while a response waits; one write in flight keeps the slave simple
    assign axi_rsp.awready = !aw_full_r && !bvalid_r;
    assign axi_rsp.wready = !w_full_r && !bvalid_r;
    assign axi_rsp.bvalid = bvalid_r;
    assign axi_rsp.bresp = bresp_r;
    assign axi_rsp.arready = !rvalid_r;
    assign axi_rsp.rvalid = rvalid_r;
    assign axi_rsp.rdata = rdata_r;
    assign axi_rsp.rresp = rresp_r;
    // data outputs straight from flops
    assign train_width = train_width_r;
    assign init_done = init_done_r;

    // all checks run on the device clock and sleep through reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_SPEED_FIXED: assert property (ar_hs && rd_cap |=> rdata_r[3:0] == 4'h1)
        else $error("max speed field not 0x1");
    AST_WIDTH_HWINIT: assert property (init_load |=> width_r == $past(sync2_r.lane_width))
        else $error("width not loaded from lane straps");
    AST_BAD_WIDTH_X1: assert property (!width_ok(width_r) |=> train_width == 6'h01)
        else $error("invalid width did not train at x1");
    AST_TRAIN_FOLLOW: assert property (width_ok(width_r) |=> train_width == $past(width_r))
        else $error("valid width not used for training");
    AST_WIDTH_OVERRIDE: assert property (cap_load && wr_strb[0] |=> width_r[3:0] == $past(wr_data[7:4]))
        else $error("unlocked width write not stored");
    AST_WIDTH_ENCODE: assert property (init_done_r |=> (train_width == 6'h01 || train_width == 6'h02 ||
        train_width == 6'h04 || train_width == 6'h0c))
        else $error("trained width not a valid code");
    AST_POWER_STATE_SUPPORT_HARD: assert property (ar_hs && rd_cap |=> rdata_r[11:10] == 2'h3)
        else $error("power state support not 0x3");
    AST_L0S_SEPARATE: assert property (!l0s_ovr_r && !common_refclk_config_r |-> link_cap[14:12] == 3'h5)
        else $error("separate clock latency not 0x5");
    AST_L0S_COMMON: assert property (wr_ctl && ctl_new[6] && !l0s_ovr_r |=> link_cap[14:12] == 3'h3)
        else $error("common clock latency not 0x3");
    AST_COMMON_REFCLK_CONFIG_CTL: assert property (wr_ctl |=> common_refclk_config_r == $past(ctl_new[6]))
        else $error("common clock bit not stored");
    AST_L1_DEFAULT: assert property ($rose(init_done_r) |-> l1_r == 3'h2 && !cpm_r)
        else $error("L1 latency or clock removal bit wrong after init");
    AST_CPM_INIT: assert property (init_load |=> !cpm_r)
        else $error("clock removal bit set after init");
    AST_DOWN_CAPS: assert property (init_load |=> sde_r == !$past(is_upstream) &&
        dlla_r == !$past(is_upstream))
        else $error("downstream capability bits wrong");
    AST_LINK_ACTIVE: assert property (init_load |=> dlla_r == !$past(is_upstream))
        else $error("link active report bit wrong");
    AST_LBN_COMPAT: assert property (init_load && sync2_r.compat_1p1 |=> !lbn_r)
        else $error("bandwidth notify set in 1.1 mode");
    AST_LBN_DOWN: assert property (init_load && !sync2_r.compat_1p1 |=> lbn_r == !$past(is_upstream))
        else $error("bandwidth notify default wrong");
    AST_PORT_NUM: assert property (init_done_r |-> link_cap[31:22] == {port_id_r, 2'h0} &&
        port_id_r[7:3] == 5'h00)
        else $error("port number byte wrong");
    AST_PORT_RO: assert property (init_done_r |=> $stable(port_id_r))
        else $error("port number changed");
    AST_LOCKED: assert property (init_done_r && !unlock_r |=> $stable({link_cap[23:15], link_cap[9:4]}))
        else $error("locked field changed while locked");
    AST_LOCKED_WR: assert property (wr_cap && !unlock_r && !init_load |=> $stable(width_r) && $stable(l1_r))
        else $error("locked write changed a field");

    // bus: answers one cycle after the take, then stand until accepted
    AST_WR_ANSWER: assert property (do_wr |=> bvalid_r)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (ar_hs |=> rvalid_r)
        else $error("read response missing");
    AST_BVALID_HOLD: assert property (bvalid_r && !axi_req.bready |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (rvalid_r && !axi_req.rready |=> rvalid_r && $stable(rdata_r) && $stable(rresp_r))
        else $error("read response dropped early");
    AST_BUSY_REFUSE: assert property (bvalid_r |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while response pending");
    // bus: unmapped addresses answer with an error
    AST_UNMAPPED_RD: assert property (ar_hs && !(rd_cap || rd_ctl || rd_sw) |=> rdata_r == 32'h0 && rresp_r == 2'h2)
        else $error("unmapped read not refused");
    AST_UNMAPPED_WR: assert property (do_wr && !wr_mapped |=> bresp_r == 2'h2)
        else $error("unmapped write not refused");

    // main scenarios
    COV_UNLOCKED_WRITE: cover property (cap_load);
    COV_COMMON_CLK: cover property (wr_ctl ##1 common_refclk_config_r);
    COV_CAP_READ: cover property (ar_hs && rd_cap ##1 rvalid_r);
    COV_BAD_ADDR: cover property (do_wr && !wr_mapped);
    COV_BAD_WIDTH: cover property (cap_load ##1 !width_ok(width_r));
endmodule
`default_nettype wire

/* shared/plc_pkg.sv */
package plc_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_LINK_CAP = 12'h04c;
    localparam logic [11:0] ADDR_LINK_CTL = 12'h050;
    localparam logic [11:0] ADDR_SW_CTL = 12'h100;
    // link_capabilities field positions, then the link_ctl and sw_ctl bits
    localparam int SPD_LSB = 0;
    localparam int WID_LSB = 4;
    localparam int POWER_STATE_SUPPORT_LSB = 10;
    localparam int L0S_LSB = 12;
    localparam int L1_LSB = 15;
    localparam int CPM_BIT = 18;
    localparam int SDE_BIT = 19;
    localparam int DLLA_BIT = 20;
    localparam int LBN_BIT = 21;
    localparam int PORT_LSB = 24;
    localparam int COMMON_REFCLK_CONFIG_BIT = 6;
    localparam int UNLOCK_BIT = 0;
    // fixed and reset values
    localparam logic [3:0] SPEED_RST = 4'h1;
    localparam logic [1:0] POWER_STATE_SUPPORT_VAL = 2'h3;
    localparam logic [2:0] L0S_SEPARATE = 3'h5;
    localparam logic [2:0] L0S_COMMON = 3'h3;
    localparam logic [2:0] L1_RST = 3'h2;
    localparam logic CPM_RST = 1'b0;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [5:0] WIDTH_X2 = 6'h02;
    localparam logic [5:0] WIDTH_X4 = 6'h04;
    localparam logic [5:0] WIDTH_X12 = 6'h0c;
    localparam logic [2:0] UPSTREAM_PORT = 3'h0;
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } plc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } plc_axi_rsp_t;

    typedef struct packed {
        logic [5:0] lane_width;
        logic [2:0] port_index;
        logic compat_1p1;
    } plc_strap_t;
endpackage

/* testbench/plc_link_cap_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module plc_link_cap_tb;
    logic core_clk;
    logic resetn;
    plc_pkg::plc_axi_req_t axi_req;
    plc_pkg::plc_axi_rsp_t axi_rsp;
    plc_pkg::plc_strap_t strap_pins;
    logic [5:0] train_width;
    logic init_done;
    int n_fail;
    int tests_run;
    logic [31:0] rd;
    logic [1:0] rs;
    // last entry stays active for the register scenarios
    plc_pkg::plc_strap_t cfg [4] = '{{6'h01, 3'h0, 1'b0}, {6'h0c, 3'h5, 1'b1}, {6'h02, 3'h3, 1'b0}, {6'h04, 3'h2, 1'b0}};
    logic [3:0] wcode [5] = '{4'h2, 4'h1, 4'h3, 4'h0, 4'h4};
    logic [5:0] wexp [5] = '{6'h02, 6'h01, 6'h01, 6'h01, 6'h04};

    plc_link_cap DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .strap_pins(strap_pins),
        .train_width(train_width),
        .init_done(init_done)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        summarize();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_cap(logic [5:0] lw, logic [2:0] p, logic c11, logic cc);
        logic ds;
        ds = (p != plc_pkg::UPSTREAM_PORT);
        return {5'h0, p, 2'h0, ds & ~c11, ds, ds, plc_pkg::CPM_RST, plc_pkg::L1_RST,
                cc ? plc_pkg::L0S_COMMON : plc_pkg::L0S_SEPARATE, plc_pkg::POWER_STATE_SUPPORT_VAL, lw, plc_pkg::SPEED_RST};
    endfunction

    // ready flags are sampled mid-cycle: inputs only move at rising edges, so they equal the edge values
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic pa, pw, ta, tw, tb;
        pa = 1'b1;
        pw = 1'b1;
        r = 2'h3;
        @(posedge core_clk);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= s;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = pa && axi_rsp.awready === 1'b1;
            tw = pw && axi_rsp.wready === 1'b1;
            tb = axi_rsp.bvalid === 1'b1;
            if (tb) r = axi_rsp.bresp;
            @(posedge core_clk);
            if (ta) begin
                axi_req.awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                axi_req.wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (tb) begin
                axi_req.bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, ta, tr;
        pa = 1'b1;
        d = '0;
        r = 2'h3;
        @(posedge core_clk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge core_clk);
            ta = pa && axi_rsp.arready === 1'b1;
            tr = axi_rsp.rvalid === 1'b1;
            if (tr) begin
                d = axi_rsp.rdata;
                r = axi_rsp.rresp;
            end
            @(posedge core_clk);
            if (ta) begin
                axi_req.arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tr) begin
                axi_req.rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    // straps must be steady before release, since they are captured a few edges later
    task automatic do_reset(input plc_pkg::plc_strap_t s);
        @(posedge core_clk);
        resetn <= 1'b0;
        strap_pins <= s;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(negedge core_clk);
            if (init_done === 1'b1) return;
        end
        hang();
    endtask

    initial begin
        axi_req = '0;
        resetn = 1'b0;
        strap_pins = cfg[0];
        n_fail = 0;
        tests_run = 0;
        for (int i = 0; i < 4; i++) begin
            do_reset(cfg[i]);
            axi_rd(plc_pkg::ADDR_LINK_CAP, rd, rs);
            chk(rd, exp_cap(cfg[i].lane_width, cfg[i].port_index, cfg[i].compat_1p1, 1'b0));
            chk({26'h0, train_width}, {26'h0, cfg[i].lane_width});
        end
        axi_wr(plc_pkg::ADDR_LINK_CAP, 32'h0, 4'hf, rs);
        chk({30'h0, rs}, {30'h0, plc_pkg::RESP_OKAY});
        axi_rd(plc_pkg::ADDR_LINK_CAP, rd, rs);
        chk(rd, exp_cap(6'h04, 3'h2, 1'b0, 1'b0));
        axi_wr(plc_pkg::ADDR_LINK_CTL, 32'h40, 4'h1, rs);
        axi_rd(plc_pkg::ADDR_LINK_CTL, rd, rs);
        chk(rd, 32'h40);
        axi_rd(plc_pkg::ADDR_LINK_CAP, rd, rs);
        chk(rd, exp_cap(6'h04, 3'h2, 1'b0, 1'b1));
        axi_wr(plc_pkg::ADDR_LINK_CTL, 32'h0, 4'h1, rs);
        axi_rd(plc_pkg::ADDR_LINK_CAP, rd, rs);
        chk(rd, exp_cap(6'h04, 3'h2, 1'b0, 1'b0));
        axi_wr(plc_pkg::ADDR_SW_CTL, 32'h1, 4'h1, rs);
        // lane 0 only, so the latency field keeps following the clock bit
        for (int j = 0; j < 5; j++) begin
            axi_wr(plc_pkg::ADDR_LINK_CAP, {24'h0, wcode[j], 4'h0}, 4'h1, rs);
            @(posedge core_clk);
            chk({26'h0, train_width}, {26'h0, wexp[j]});
        end
        axi_wr(plc_pkg::ADDR_LINK_CAP, 32'h0, 4'h8, rs);
        axi_rd(plc_pkg::ADDR_LINK_CAP, rd, rs);
        chk(rd, exp_cap(6'h04, 3'h2, 1'b0, 1'b0));
        axi_rd(12'h200, rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, plc_pkg::RESP_SLVERR});
        axi_wr(12'h200, 32'hffffffff, 4'hf, rs);
        chk({30'h0, rs}, {30'h0, plc_pkg::RESP_SLVERR});
        summarize();
    end
endmodule
`default_nettype wire
